// *** verilog/adcphi_host_port.sv ***
// Parallel host port of a 12-bit converter
// Functional notes
// - Completion flag goes low when a conversion finishes and data is ready.
// - With chip select low, a read strobe fall starts driving the result.
// - Internal acquisition: write rise latches config and, in int or ext clock mode only, starts acq plus conv.
// - External acquisition: first write rise starts acq, second ends it and starts conv.
// - Chip select high floats the completion flag and all twelve data lines.
// - Low eight data lines are bidirectional, the top four output only.
// - Config bit five selects internal (0) or external (1) acquisition.
// - Config bits seven and six select power-down, standby, int or ext clock.
// - A read strobe fall returns the completion flag high.
`timescale 1ns/1ps
`default_nettype none
module adcphi_host_port
(
   input  wire logic                       sys_clk,
   input  wire logic                       nrst,
   input  wire logic                       csN,
   input  wire logic                       rdN,
   input  wire logic                       wrN,
   input  wire logic                       convClk,
   input  wire logic [7:0]                 dataIn,
   input  wire logic [adcphi_pkg::DataW-1:0] sampleIn,
   output var  logic [adcphi_pkg::DataW-1:0] dataOut,
   output var  logic [adcphi_pkg::DataW-1:0] dataOeN,
   output var  logic                       doneN,
   output var  logic                       doneOeN,
   output var  logic [adcphi_pkg::CfgW-1:0] cfgOut,
   output var  logic                       busy
);
   adcphi_pkg::adcphi_pins_t meta_q;
   adcphi_pkg::adcphi_pins_t pin_q;
   adcphi_pkg::adcphi_pins_t prev_q;
   logic [7:0]               dataMeta_q;
   logic [7:0]               dataSync_q;
   adcphi_pkg::adcphi_state_t state_q;
   logic [3:0]               tick_q;
   logic [2:0]               div_q;
   logic                     reading_q;
   logic                     convFall;
   logic                     intTick;
   logic                     tick;
   logic                     wrRise;
   logic                     rdFall;
   logic                     extAcq;
   logic                     convEnd;
   adcphi_pkg::adcphi_pwr_t  pwr;

   // Edge detectors on synchronised pins
   function automatic logic fellEdge(input logic cur, input logic prv);
      return !cur && prv;
   endfunction

   // Last tick of a counted phase
   function automatic logic atLast(input logic [3:0] cnt, input int len);
      return cnt == 4'(len - 1);
   endfunction

   // Two-stage synchronisers for pins
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         meta_q     <= '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, clk: 1'b0};
         pin_q      <= '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, clk: 1'b0};
         prev_q     <= '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, clk: 1'b0};
         dataMeta_q <= 8'h00;
         dataSync_q <= 8'h00;
      end
      else
      begin
         meta_q     <= '{csN: csN, rdN: rdN, wrN: wrN, clk: convClk};
         pin_q      <= meta_q;
         prev_q     <= pin_q;
         dataMeta_q <= dataIn;
         dataSync_q <= dataMeta_q;
      end
   end

   assign wrRise   = !pin_q.csN && pin_q.wrN && !prev_q.wrN;
   assign rdFall   = !pin_q.csN && fellEdge(pin_q.rdN, prev_q.rdN);
   assign convFall = fellEdge(pin_q.clk, prev_q.clk);
   // Last conversion tick ends the cycle
   assign convEnd  = (state_q == adcphi_pkg::StConv) && tick
                     && atLast(tick_q, adcphi_pkg::ConvTicks);
   assign pwr      = adcphi_pkg::adcphi_pwr_t'(
                        cfgOut[adcphi_pkg::PwrHiPos:adcphi_pkg::PwrLoPos]);
   assign extAcq   = cfgOut[adcphi_pkg::AcqModePos];
   assign intTick  = (div_q == 3'(adcphi_pkg::IntClkDiv - 1));
   // External clock ticks on its falling edge internal from divider
   assign tick     = (pwr == adcphi_pkg::PwrExtClk) ? convFall : intTick;

   // Internal conversion clock divider
   always_ff @(posedge sys_clk)
   begin
      if (!nrst || intTick)
         div_q <= 3'h0;
      else
         div_q <= div_q + 3'h1;
   end

   // Configuration capture on write rise
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         cfgOut <= adcphi_pkg::CfgReset;
      else if (wrRise && state_q == adcphi_pkg::StIdle)
         cfgOut <= {dataSync_q};
   end

   // Acquisition and conversion sequencer
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         state_q <= adcphi_pkg::StIdle;
         tick_q  <= 4'h0;
      end
      else
      begin
         case (state_q)
            adcphi_pkg::StIdle:
               if (wrRise)
               begin
                  tick_q <= 4'h0;
                  if (dataSync_q[adcphi_pkg::AcqModePos])
                     state_q <= adcphi_pkg::StAcq;
                  else if (dataSync_q[adcphi_pkg::PwrHiPos])
                     state_q <= adcphi_pkg::StAcq;
               end
            adcphi_pkg::StAcq:
               if (extAcq)
               begin
                  if (wrRise)
                  begin
                     state_q <= adcphi_pkg::StConv;
                     tick_q  <= 4'h0;
                  end
               end
               else if (tick)
               begin
                  if (atLast(tick_q, adcphi_pkg::AcqTicks))
                  begin
                     state_q <= adcphi_pkg::StConv;
                     tick_q  <= 4'h0;
                  end
                  else
                     tick_q <= tick_q + 4'h1;
               end
            adcphi_pkg::StConv:
               if (tick)
               begin
                  if (convEnd)
                     state_q <= adcphi_pkg::StIdle;
                  else
                     tick_q <= tick_q + 4'h1;
               end
            default:
               state_q <= adcphi_pkg::StIdle;
         endcase
      end
   end

   // Busy while acquiring or converting
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         busy <= 1'b0;
      else
         busy <= (state_q != adcphi_pkg::StIdle);
   end

   // Result latch and completion flag
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         doneN   <= 1'b1;
         dataOut <= 12'h000;
      end
      else if (convEnd)
      begin
         doneN   <= 1'b0;
         dataOut <= sampleIn;
      end
      else if (rdFall)
         doneN <= 1'b1;
   end

   // Read window tracking
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         reading_q <= 1'b0;
      else if (pin_q.csN || pin_q.rdN)
         reading_q <= 1'b0;
      else if (rdFall)
         reading_q <= 1'b1;
   end

   // Output enables, low while driving
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         dataOeN <= 12'hfff;
         doneOeN <= 1'b1;
      end
      else
      begin
         doneOeN <= pin_q.csN;
         // All twelve lines enabled together; low eight shared with input
         dataOeN <= {adcphi_pkg::DataW{pin_q.csN || pin_q.rdN
                    || !(reading_q || rdFall)}};
      end
   end
endmodule // adcphi_host_port
`default_nettype wire

// *** verilog/adcphi_pkg.sv ***
// Package for the converter parallel host port
`default_nettype none
package adcphi_pkg;
   localparam int DataW       = 12;
   localparam int CfgW        = 8;
   // Configuration byte fields
   localparam int PwrHiPos    = 7;
   localparam int PwrLoPos    = 6;
   localparam int AcqModePos  = 5;
   // Conversion timing in conversion-clock ticks
   localparam int AcqTicks    = 4;
   localparam int ConvTicks   = 12;
   // Internal conversion clock divider (40 MHz / 8 = 5 MHz)
   localparam int IntClkDiv   = 8;
   localparam logic [CfgW-1:0] CfgReset = 8'h80;

   typedef enum logic [1:0]
   {
      PwrFull    = 2'b00,
      PwrStandby = 2'b01,
      PwrIntClk  = 2'b10,
      PwrExtClk  = 2'b11
   } adcphi_pwr_t;

   typedef enum logic [1:0]
   {
      StIdle = 2'b00,
      StAcq  = 2'b01,
      StConv = 2'b10
   } adcphi_state_t;

   // Host-side strobes after synchronisation
   typedef struct packed
   {
      logic csN;
      logic rdN;
      logic wrN;
      logic clk;
   } adcphi_pins_t;
endpackage
`default_nettype wire

// *** dv/adcphi_chk.sv ***
// Assertion checker for the converter host port
`timescale 1ns/1ps
`default_nettype none
module adcphi_chk
(
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        csN,
   input wire logic        rdN,
   input wire logic        wrN,
   input wire logic [7:0]  dataIn,
   input wire logic [11:0] dataOeN,
   input wire logic        doneN,
   input wire logic        doneOeN,
   input wire logic [7:0]  cfgOut,
   input wire logic        busy
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence rdFall; $fell(rdN) && !csN && !busy; endsequence
   sequence wrIdle; $rose(wrN) && !csN && !busy; endsequence
   AST_FLOAT: assert property (csN && $past(csN) && $past(csN, 2)
      && $past(csN, 3) |-> doneOeN && dataOeN == 12'hfff)
      else $error("outputs not floated");
   AST_OE_CS: assert property ($fell(csN) |-> ##[2:4] !doneOeN)
      else $error("flag not driven");
   AST_OE_SAME: assert property (dataOeN == 12'h000 || dataOeN == 12'hfff)
      else $error("data enables split");
   AST_READ: assert property (rdFall |-> ##[2:4] dataOeN == 12'h000)
      else $error("read did not drive data");
   AST_CLR: assert property (rdFall |-> ##[2:4] doneN)
      else $error("flag not cleared by read");
   AST_DONE: assert property ($fell(busy) |-> ##[0:2] !doneN)
      else $error("flag not set at completion");
   AST_CFG: assert property (wrIdle |-> ##[2:4] cfgOut == dataIn)
      else $error("config not latched");
   AST_START: assert property (wrIdle ##0 dataIn[7] |-> ##[3:5] busy)
      else $error("cycle not started");
   AST_PWRDN: assert property (wrIdle ##0 dataIn[7:5] == 3'h0
      |-> ##1 (!busy)[*6]) else $error("power-down started a cycle");
   AST_HOLD: assert property (busy && $past(busy) |-> $stable(cfgOut))
      else $error("config changed while busy");
endmodule // adcphi_chk
bind adcphi_host_port adcphi_chk chk_u (.sys_clk(sys_clk), .nrst(nrst),
   .csN(csN), .rdN(rdN), .wrN(wrN), .dataIn(dataIn), .dataOeN(dataOeN),
   .doneN(doneN), .doneOeN(doneOeN), .cfgOut(cfgOut), .busy(busy));
`default_nettype wire

// *** dv/adcphi_host_model.sv ***
// Host clock source for external clock mode
`timescale 1ns/1ps
`default_nettype none
module adcphi_host_model
(
   input  wire logic runClk,
   output var  logic convClk
);
   initial convClk = 1'b0;
   // Free running only in external clock mode, else tied low
   always #50 convClk = runClk ? ~convClk : 1'b0;
endmodule // adcphi_host_model
`default_nettype wire

// *** dv/testbench.sv ***
// Testbench for the converter host port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin failures++; \
   $display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench;
   logic sys_clk = 1'b0;
   logic nrst, csN, rdN, wrN, convClk, doneN, doneOeN, busy;
   logic [7:0]  dataIn, cfgOut;
   logic [11:0] smp, dataOut, dataOeN;
   int failures = 0;
   int cmp_count = 0;
   always #12.5 sys_clk = ~sys_clk;
   adcphi_host_model host_u (.runClk(cfgOut[7:6] == 2'b11), .convClk(convClk));
   adcphi_host_port dut_u (.sys_clk(sys_clk), .nrst(nrst), .csN(csN),
      .rdN(rdN), .wrN(wrN), .convClk(convClk), .dataIn(dataIn),
      .sampleIn(smp), .dataOut(dataOut), .dataOeN(dataOeN), .doneN(doneN),
      .doneOeN(doneOeN), .cfgOut(cfgOut), .busy(busy));
   task automatic hold(int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Write strobe pulse, bus held; next low only after spacing
   task automatic wr(logic [7:0] b);
      dataIn <= b;
      csN <= 1'b0;
      hold(4);
      wrN <= 1'b0;
      hold(4);
      wrN <= 1'b1;
      hold(10);
   endtask
   task automatic waitDone();
      int i;
      i = 0;
      while (doneN !== 1'b0 && i < 1000)
      begin
         hold(1);
         i++;
      end
      `CHK("doneN", 1'b0, doneN)
   endtask
   task automatic rd(logic [11:0] e);
      csN <= 1'b0;
      hold(4);
      rdN <= 1'b0;
      hold(6);
      `CHK("dataOut", e, dataOut)
      `CHK("dataOeN", 12'h000, dataOeN)
      `CHK("doneN", 1'b1, doneN)
      `CHK("doneOeN", 1'b0, doneOeN)
      rdN <= 1'b1;
      csN <= 1'b1;
      hold(6);
      `CHK("dataOeN", 12'hfff, dataOeN)
      `CHK("doneOeN", 1'b1, doneOeN)
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      hold(20000);
      failures++;
      print_verdict();
   end
   initial
   begin
      logic [7:0] pd [2];
      pd = '{8'h00, 8'h40};
      nrst <= 1'b0;
      csN <= 1'b1;
      rdN <= 1'b1;
      wrN <= 1'b1;
      dataIn <= 8'h00;
      smp <= 12'ha5c;
      hold(20);
      nrst <= 1'b1;
      hold(2);
      `CHK("cfgOut", 8'h80, cfgOut)
      `CHK("dataOeN", 12'hfff, dataOeN)
      wr(8'h80);
      waitDone();
      rd(12'ha5c);
      $display("test internal acquisition done");
      smp <= 12'h3a1;
      wr(8'h81);
      hold(40);
      wr(8'h9f);
      `CHK("cfgOut", 8'h81, cfgOut)
      waitDone();
      rd(12'h3a1);
      $display("test refused write done");
      for (int i = 0; i < 2; i++)
      begin
         wr(pd[i]);
         hold(40);
         `CHK("cfgOut", pd[i], cfgOut)
         `CHK("busy", 1'b0, busy)
      end
      $display("test power-down done");
      smp <= 12'h5c3;
      wr(8'ha0);
      hold(30);
      `CHK("doneN", 1'b1, doneN)
      wr(8'hbf);
      waitDone();
      `CHK("cfgOut", 8'ha0, cfgOut)
      rd(12'h5c3);
      $display("test external acquisition done");
      smp <= 12'hc3a;
      wr(8'hc0);
      waitDone();
      rd(12'hc3a);
      $display("test external clock done");
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
